// ---- src/ipr_resolver.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipr_resolver
	import ipr_pkg::*;
(
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       hsel,
	input  wire logic [ipr_pkg::HADDR_W-1:0] haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output var  logic                       hreadyout,
	output var  logic                       hresp,
	output var  logic [31:0]                hrdata,
	input  wire logic [ipr_pkg::NUM_SLOTS-1:0] irq_req,
	input  wire logic [ipr_pkg::NUM_TRAPS-1:0] trap_req,
	input  wire logic [2:0]                 cpu_ipl,
	input  wire logic                       timed_irq_block_instruction,
	output var  logic                       irq_to_cpu,
	output var  logic [3:0]                 new_cpu_priority_level,
	output var  logic [6:0]                 pending_vector_number
);
	import ipr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [15:0]                reg_val [NUM_PRIO_REGS];
	logic [NUM_PRIO_REGS-1:0]   reg_we;
	logic [PRIO_W-1:0]          slot_prio [NUM_SLOTS];
	logic [NUM_SLOTS-1:0]       slot_impl;
	logic [NUM_SLOTS-1:0]       slot_ok;
	logic                       dp_valid;
	logic                       dp_write;
	logic                       dp_hit;
	logic [3:0]                 dp_reg;
	logic                       next_dp_valid;
	logic                       next_dp_write;
	logic                       next_dp_hit;
	logic [3:0]                 next_dp_reg;
	logic                       ap_take;
	logic                       ap_hit;
	logic [3:0]                 ap_reg;
	logic [31:0]                next_hrdata;
	logic [15:0]                stat;
	logic [15:0]                next_stat;
	logic                       found;
	logic                       trap_found;
	logic [LEVEL_W-1:0]         best_lvl;
	logic [VEC_W-1:0]           best_vec;
	logic                       next_irq;
	logic [3:0]                 next_lvl;
	logic [6:0]                 next_vec;

	////////////////////////////////////////////////////////////////////////
	// priority registers, one cell per word
	for (genvar r = 0; r < NUM_PRIO_REGS; r++)
	begin : g_prio
		ipr_prio_reg #(
			.RESET_VAL (PRIO_RESET[r]),
			.MASK      (ipr_mask(PRIO_RESET[r]))
		) u_reg (
			.hclk    (hclk),
			.hresetn (hresetn),
			.wr_en   (reg_we[r]),
			.wr_data (hwdata[15:0]),
			.value   (reg_val[r])
		);
		assign reg_we[r] = dp_valid && dp_write && dp_hit
			&& (dp_reg == 4'(r));
	end

	// slot s sits in word s/4, nibble s%4; slot order is vector order
	for (genvar s = 0; s < NUM_SLOTS; s++)
	begin : g_slot
		localparam logic [15:0] WORD_MASK =
			ipr_mask(PRIO_RESET[s/SLOTS_PER_REG]);
		assign slot_prio[s] = reg_val[s/SLOTS_PER_REG][(s%4)*4 +: PRIO_W];
		assign slot_impl[s] = WORD_MASK[(s%4)*4];
		// block gates levels below 7 only
		assign slot_ok[s] = slot_impl[s] && irq_req[s]
			&& (slot_prio[s] != 3'h0) && (slot_prio[s] > cpu_ipl)
			&& (!timed_irq_block_instruction
			|| (slot_prio[s] == LEVEL_UNMASKABLE));
	end

	// the vector field must hold every slot above the trap vectors
	if (int'(VEC_IRQ_BASE) + NUM_SLOTS > (1 << VEC_W))
	begin : g_bad_vec
		$error("vector field too narrow for the slot count");
	end

	////////////////////////////////////////////////////////////////////////
	// address phase decode; a failed match leaves the slot unmapped
	always_comb
	begin
		ap_take = hsel && htrans[1] && hready && (hsize == HSIZE_WORD)
			&& (haddr[1:0] == 2'h0);
		ap_hit  = 1'b0;
		ap_reg  = 4'hf;
		for (int r = 0; r < NUM_PRIO_REGS; r++)
		begin
			if (haddr[HADDR_W-1:2] == {2'h0, PRIO_IDX[r]})
			begin
				ap_hit = 1'b1;
				ap_reg = 4'(r);
			end
		end
		if (haddr[HADDR_W-1:2] == {2'h0, IDX_LEVEL_VECTOR_STATUS})
		begin
			ap_hit = 1'b1;
			ap_reg = 4'hf;
		end
	end

	// data phase state and read data; zero wait states throughout
	always_comb
	begin
		next_dp_valid = ap_take;
		next_dp_write = ap_take && hwrite;
		next_dp_hit   = ap_take && ap_hit;
		next_dp_reg   = ap_reg;
		next_hrdata   = 32'h0000_0000;
		if (ap_take && !hwrite && ap_hit)
		begin
			if (ap_reg == 4'hf)
				next_hrdata = {16'h0000, stat & STAT_MASK};
			else if (reg_we[ap_reg])
				// forward a write still in its data phase
				next_hrdata = {16'h0000,
					hwdata[15:0] & ipr_mask(PRIO_RESET[ap_reg])};
			else
				next_hrdata = {16'h0000, reg_val[ap_reg]};
		end
	end

	// bus registers; the slave never stretches or errors
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_valid  <= 1'b0;
			dp_write  <= 1'b0;
			dp_hit    <= 1'b0;
			dp_reg    <= 4'h0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			dp_valid  <= next_dp_valid;
			dp_write  <= next_dp_write;
			dp_hit    <= next_dp_hit;
			dp_reg    <= next_dp_reg;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// resolver: traps first, then highest user level
	always_comb
	begin
		found      = 1'b0;
		trap_found = 1'b0;
		best_lvl   = 4'h0;
		best_vec   = 7'h00;
		// lowest trap index wins by scanning downward
		for (int t = NUM_TRAPS - 1; t >= 0; t--)
		begin
			if (trap_req[t])
			begin
				trap_found = 1'b1;
				best_lvl   = TRAP_LEVEL;
				best_vec   = 7'(t);
			end
		end
		found = trap_found;
		if (!trap_found)
		begin
			// lower slot means lower vector address
			for (int s = NUM_SLOTS - 1; s >= 0; s--)
			begin
				if (slot_ok[s] && ({1'b0, slot_prio[s]} >= best_lvl))
				begin
					found    = 1'b1;
					best_lvl = {1'b0, slot_prio[s]};
					best_vec = VEC_IRQ_BASE + 7'(s);
				end
			end
		end
	end

	// status, level and vector outputs hold the last winner; irq_to_cpu follows found each cycle
	always_comb
	begin
		next_stat = stat;
		next_irq  = found;
		next_lvl  = new_cpu_priority_level;
		next_vec  = pending_vector_number;
		if (found)
		begin
			next_stat = ({4'h0, best_lvl, 1'b0, best_vec}) & STAT_MASK;
			next_lvl  = best_lvl;
			next_vec  = best_vec;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stat                   <= STAT_RESET;
			irq_to_cpu             <= 1'b0;
			new_cpu_priority_level <= STAT_RESET[STAT_LVL_LSB +: 4];
			pending_vector_number  <= STAT_RESET[STAT_VEC_LSB +: 7];
		end
		else
		begin
			stat                   <= next_stat;
			irq_to_cpu             <= next_irq;
			new_cpu_priority_level <= next_lvl;
			pending_vector_number  <= next_vec;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	tie_lower_slot_a: assert property (
		(!(|trap_req) && slot_ok[1] && slot_ok[2] && !slot_ok[0]
			&& slot_prio[1] == slot_prio[2]
			&& {1'b0, slot_prio[1]} == best_lvl)
		|=> pending_vector_number == VEC_IRQ_BASE + 7'd1)
		else $error("equal level tie not granted to lower slot");

	natural_order_first_a: assert property (
		(!(|trap_req) && found)
		|-> !(slot_ok[0] && {1'b0, slot_prio[0]} == best_lvl
			&& best_vec != VEC_IRQ_BASE))
		else $error("lowest vector not preferred at its level");

	level7_unblocked_a: assert property (
		(timed_irq_block_instruction && irq_req[5]
			&& slot_prio[5] == LEVEL_UNMASKABLE
			&& cpu_ipl != LEVEL_UNMASKABLE)
		|=> irq_to_cpu && new_cpu_priority_level >= 4'h7)
		else $error("level 7 source blocked by timed block");

	trap_unblocked_a: assert property (
		(timed_irq_block_instruction && trap_req[2]
			&& trap_req[1:0] == 2'b00)
		|=> irq_to_cpu && pending_vector_number == 7'h02
			&& new_cpu_priority_level == TRAP_LEVEL)
		else $error("trap blocked by timed block");

	low_level_blocked_a: assert property (
		(timed_irq_block_instruction && !(|trap_req))
		|=> !irq_to_cpu || new_cpu_priority_level == 4'h7)
		else $error("level below 7 taken under timed block");

	trap_level_a: assert property (
		(|trap_req)
		|=> irq_to_cpu && new_cpu_priority_level == TRAP_LEVEL)
		else $error("pending trap not reported at trap level");

	idle_no_irq_a: assert property (
		(!(|trap_req) && !(|slot_ok)) |=> !irq_to_cpu)
		else $error("request raised with no eligible source");

	reset_image_a: assert property (
		$rose(hresetn) |-> reg_val[3] == 16'h4404
			&& reg_val[14] == 16'h4400 && reg_val[7] == 16'h0004)
		else $error("priority reset image wrong");

	reserved_zero_a: assert property (
		reg_we[0] |=> reg_val[0] == ($past(hwdata[15:0]) & 16'h7777)
			&& (hrdata[31:16] == 16'h0000))
		else $error("reserved priority bits not zero");

	status_tracks_a: assert property (
		found |=> irq_to_cpu
			&& stat[STAT_LVL_LSB +: 4] == new_cpu_priority_level
			&& stat[STAT_VEC_LSB +: 7] == pending_vector_number
			&& stat[15:12] == 4'h0 && stat[7] == 1'b0)
		else $error("status not matching taken interrupt");

	status_readonly_a: assert property (
		(dp_valid && dp_write && dp_reg == 4'hf && !found)
		|=> $stable(stat))
		else $error("status register changed by a bus write");

endmodule : ipr_resolver
`default_nettype wire

// ---- src/ipr_pkg.sv ----
package ipr_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NUM_PRIO_REGS = 15;
	localparam int SLOTS_PER_REG = 4;
	localparam int NUM_SLOTS     = NUM_PRIO_REGS * SLOTS_PER_REG;
	localparam int NUM_TRAPS     = 8;
	localparam int HADDR_W       = 12;
	localparam int REG_IDX_W     = 8;
	localparam int PRIO_W        = 3;
	localparam int LEVEL_W       = 4;
	localparam int VEC_W         = 7;

	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_UART1_RX_SPI1_TIMER3       = 8'ha8;
	localparam logic [7:0] IDX_DMA1_ADC1_UART1_TX         = 8'haa;
	localparam logic [7:0] IDX_CHANGE_NOTICE_COMP_I2C     = 8'hac;
	localparam logic [7:0] IDX_INPUT_CAPTURE_EXT1         = 8'hae;
	localparam logic [7:0] IDX_TIMER4_COMPARE_DMA2        = 8'hb0;
	localparam logic [7:0] IDX_UART2_EXT2_TIMER5          = 8'hb2;
	localparam logic [7:0] IDX_CAN1_SPI2                  = 8'hb4;
	localparam logic [7:0] IDX_DMA3                       = 8'hb6;
	localparam logic [7:0] IDX_DMA4_PARALLEL_PORT         = 8'hb8;
	localparam logic [7:0] IDX_CODEC_ERR_QUADRATURE1_PWM1 = 8'hba;
	localparam logic [7:0] IDX_FAULT1_RTC_DMA5_CODEC      = 8'hbc;
	localparam logic [7:0] IDX_CRC_UART_ERRORS            = 8'hbe;
	localparam logic [7:0] IDX_CAN1_TX_DMA6_DMA7          = 8'hc6;
	localparam logic [7:0] IDX_QUADRATURE2_FAULT2_PWM2    = 8'hc8;
	localparam logic [7:0] IDX_AUDIO_DAC_CHANNELS         = 8'hca;
	localparam logic [7:0] IDX_LEVEL_VECTOR_STATUS        = 8'he0;

	// priority registers in vector-table order (slot order)
	localparam logic [7:0] PRIO_IDX [NUM_PRIO_REGS] = '{
		IDX_UART1_RX_SPI1_TIMER3, IDX_DMA1_ADC1_UART1_TX,
		IDX_CHANGE_NOTICE_COMP_I2C, IDX_INPUT_CAPTURE_EXT1,
		IDX_TIMER4_COMPARE_DMA2, IDX_UART2_EXT2_TIMER5,
		IDX_CAN1_SPI2, IDX_DMA3, IDX_DMA4_PARALLEL_PORT,
		IDX_CODEC_ERR_QUADRATURE1_PWM1, IDX_FAULT1_RTC_DMA5_CODEC,
		IDX_CRC_UART_ERRORS, IDX_CAN1_TX_DMA6_DMA7,
		IDX_QUADRATURE2_FAULT2_PWM2, IDX_AUDIO_DAC_CHANNELS};

	// reset images; a nibble of 4 marks an implemented field
	localparam logic [15:0] PRIO_RESET [NUM_PRIO_REGS] = '{
		16'h4444, 16'h0444, 16'h4444, 16'h4404, 16'h4444,
		16'h4444, 16'h4444, 16'h0004, 16'h0440, 16'h4440,
		16'h4444, 16'h4440, 16'h0444, 16'h4440, 16'h4400};

	////////////////////////////////////////////////////////////////////////
	// status register layout
	localparam int          STAT_VEC_LSB = 0;
	localparam int          STAT_LVL_LSB = 8;
	localparam logic [15:0] STAT_MASK    = 16'h0f7f;
	localparam logic [15:0] STAT_RESET   = 16'h4444 & STAT_MASK;

	////////////////////////////////////////////////////////////////////////
	// resolution constants
	localparam logic [6:0] VEC_IRQ_BASE     = 7'h08;
	localparam logic [3:0] TRAP_LEVEL       = 4'h8;
	localparam logic [2:0] LEVEL_UNMASKABLE = 3'h7;
	localparam logic [2:0] HSIZE_WORD       = 3'h2;

	// implemented-bit mask derived from a reset image
	function automatic logic [15:0] ipr_mask(input logic [15:0] rst);
		logic [15:0] m;
		m = 16'h0000;
		for (int n = 0; n < SLOTS_PER_REG; n++)
		begin
			if (rst[n*4 +: 4] != 4'h0)
				m[n*4 +: 3] = 3'h7;
		end
		return m;
	endfunction : ipr_mask

endpackage : ipr_pkg

// ---- src/ipr_prio_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipr_prio_reg #(
	parameter logic [15:0] RESET_VAL = 16'h4444,
	parameter logic [15:0] MASK      = 16'h7777
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	output var  logic [15:0] value
);
	logic [15:0] next_value;

	// masked bits never take a write
	always_comb
	begin
		next_value = value;
		if (wr_en)
			next_value = wr_data & MASK;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			value <= RESET_VAL & MASK;
		else
			value <= next_value;
	end
endmodule : ipr_prio_reg
`default_nettype wire

// ---- tb/ipr_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// cpu side: sets its level and latches what the resolver reports
module ipr_cpu_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [2:0]  ipl_set,
	input  wire logic        irq_to_cpu,
	input  wire logic [3:0]  level_in,
	input  wire logic [6:0]  vector_in,
	output var  logic [2:0]  cpu_ipl,
	output var  logic [11:0] seen
);
	// registered so the bench reads a settled copy, never the edge itself
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cpu_ipl <= 3'h0;
			seen    <= 12'h000;
		end
		else
		begin
			cpu_ipl <= ipl_set;
			seen    <= {irq_to_cpu, level_in, vector_in};
		end
	end
endmodule : ipr_cpu_model
`default_nettype wire

// ---- tb/interrupt_priority_resolver_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_resolver_tb_top;
	import ipr_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout, hresp, irq_to_cpu;
	logic [31:0] hrdata;
	logic [32:0] rd_got;
	logic [59:0] irq_req = 60'h0;
	logic [7:0]  trap_req = 8'h00;
	logic [2:0]  ipl_set = 3'h0;
	logic [2:0]  cpu_ipl;
	logic        block_on = 1'b0;
	logic [3:0]  lvl;
	logic [6:0]  vec;
	logic [11:0] seen;
	logic [32:0] rd_q[$];
	logic [11:0] irq_q[$];
	logic [15:0] w;
	int          fails = 0;
	int          n_checks = 0;
	event        rd_ev, irq_ev;

	always #2.5 hclk = ~hclk;

	ipr_resolver ipr_resolver_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .irq_req(irq_req), .trap_req(trap_req),
		.cpu_ipl(cpu_ipl), .timed_irq_block_instruction(block_on),
		.irq_to_cpu(irq_to_cpu), .new_cpu_priority_level(lvl),
		.pending_vector_number(vec));

	ipr_cpu_model ipr_cpu_model_inst (
		.hclk(hclk), .hresetn(hresetn), .ipl_set(ipl_set),
		.irq_to_cpu(irq_to_cpu), .level_in(lvl), .vector_in(vec),
		.cpu_ipl(cpu_ipl), .seen(seen));

	////////////////////////////////////////////////////////////////////////
	// byte address of a register index
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ad

	// three-bit fields of every nibble that resets nonzero
	function automatic logic [15:0] msk(input logic [15:0] r);
		msk = 16'h0000;
		for (int n = 0; n < 4; n++)
			if (r[n*4 +: 4] !== 4'h0)
				msk[n*4 +: 3] = 3'h7;
	endfunction : msk

	// one single transfer; each phase held until hready is seen high
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [15:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		@(posedge hclk);
		// only the watchdog ends a wait that never sees hready
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= {16'h0000, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd_got = {hresp, hrdata};
	endtask : bus

	// the note carries the response code above the read data
	task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
		rd_q.push_back({1'b0, 16'h0000, e});
		bus(1'b0, a, 16'h0000);
		-> rd_ev;
	endtask : rd_chk

	// outputs follow inputs one edge later; the cpu copy one more
	task automatic irq_chk(input logic [59:0] r, input logic [7:0] t,
		input logic [11:0] e);
		irq_req  <= r;
		trap_req <= t;
		irq_q.push_back(e);
		repeat (2) @(posedge hclk);
		-> irq_ev;
	endtask : irq_chk

	task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] hresp_hrdata expected %h seen %h", e, g);
		end
	endtask : cmp_rd

	task automatic cmp_irq(input logic [11:0] e, input logic [11:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] irq_level_vector expected %h seen %h", e, g);
		end
	endtask : cmp_irq

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////
	// watchers take the oldest note off each queue as a result appears
	always
	begin
		@(rd_ev);
		cmp_rd(rd_q.pop_front(), rd_got);
	end

	always
	begin
		@(irq_ev);
		#1;
		cmp_irq(irq_q.pop_front(), seen);
	end

	// watchdog; the whole sequence needs well under a thousand cycles
	initial
	begin
		#100000;
		fails++;
		results();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		void'($urandom(32'hcae1));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < NUM_PRIO_REGS; i++)
		begin
			w = PRIO_RESET[i] & msk(PRIO_RESET[i]);
			rd_chk(ad(PRIO_IDX[i]), w);
		end
		rd_chk(ad(IDX_LEVEL_VECTOR_STATUS), 16'h0444);
		// random images; reserved bits must drop, then all cleared
		for (int i = 0; i < NUM_PRIO_REGS; i++)
		begin
			w = 16'($urandom);
			bus(1'b1, ad(PRIO_IDX[i]), w);
			rd_chk(ad(PRIO_IDX[i]), w & msk(PRIO_RESET[i]));
			bus(1'b1, ad(PRIO_IDX[i]), 16'h0000);
		end
		bus(1'b1, ad(IDX_LEVEL_VECTOR_STATUS), 16'hffff);
		rd_chk(ad(IDX_LEVEL_VECTOR_STATUS), 16'h0444);
		bus(1'b1, 12'hffc, 16'hffff);
		rd_chk(12'hffc, 16'h0000);
		// slots 0..2 at 5, slot 5 at 6
		bus(1'b1, ad(IDX_UART1_RX_SPI1_TIMER3), 16'h0555);
		bus(1'b1, ad(IDX_DMA1_ADC1_UART1_TX), 16'h0060);
		irq_chk(60'h6, 8'h00, {1'b1, 4'h5, 7'd9});
		irq_chk(60'h5, 8'h00, {1'b1, 4'h5, 7'd8});
		irq_chk(60'h22, 8'h00, {1'b1, 4'h6, 7'd13});
		irq_chk(60'h0, 8'h00, {1'b0, 4'h6, 7'd13});
		rd_chk(ad(IDX_LEVEL_VECTOR_STATUS), 16'h060d);
		block_on <= 1'b1;
		irq_chk(60'h20, 8'h00, {1'b0, 4'h6, 7'd13});
		bus(1'b1, ad(IDX_DMA1_ADC1_UART1_TX), 16'h0070);
		irq_chk(60'h20, 8'h00, {1'b1, 4'h7, 7'd13});
		irq_chk(60'h20, 8'h0c, {1'b1, 4'h8, 7'd2});
		rd_chk(ad(IDX_LEVEL_VECTOR_STATUS), 16'h0802);
		block_on <= 1'b0;
		ipl_set  <= 3'h6;
		irq_chk(60'h0, 8'h00, {1'b0, 4'h8, 7'd2});
		// a source must sit above the cpu level to be taken
		irq_chk(60'h2, 8'h00, {1'b0, 4'h8, 7'd2});
		repeat (4) @(posedge hclk);
		results();
	end
endmodule : interrupt_priority_resolver_tb_top
`default_nettype wire
